// [rtl/scp_pkg.sv]
// Constants, types and helpers shared by the screen and table command parser.
package scp_pkg;

  typedef logic [7:0] scp_byte_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CODE, ST_PARM, ST_STR, ST_COPY
  } scp_st_e;

  typedef enum logic [2:0] {
    C_NONE, C_SCR, C_STR, C_NUM4, C_NUM8, C_COPY
  } scp_cmd_e;

  typedef enum logic [1:0] {
    TX_NONE, TX_SCR, TX_NUM
  } scp_tx_e;

  // Framing bytes and command codes.
  localparam scp_byte_t ESC          = 8'h1B;
  localparam scp_byte_t CR           = 8'h0D;
  localparam scp_byte_t CODE_SCR     = 8'h30;
  localparam scp_byte_t CODE_ENQ     = 8'h31;
  localparam scp_byte_t CODE_STR     = 8'h41;
  localparam scp_byte_t CODE_NUM4    = 8'h43;
  localparam scp_byte_t CODE_NUM8    = 8'h44;
  localparam scp_byte_t CODE_COPY    = 8'h2F;
  localparam scp_byte_t CODE_SCR_RSP = 8'h59;
  localparam scp_byte_t CODE_NUM_NTF = 8'h46;

  // ASCII digit ranges.
  localparam scp_byte_t ASC_ZERO  = 8'h30;
  localparam scp_byte_t ASC_NINE  = 8'h39;
  localparam scp_byte_t ASC_A     = 8'h41;
  localparam scp_byte_t ASC_F     = 8'h46;
  localparam scp_byte_t ASC_A_OFS = 8'h37;
  localparam scp_byte_t MARK_MIN  = 8'h80;

  // Parameter digit counts per command.
  localparam logic [3:0] PARM_SCR  = 4'h4;
  localparam logic [3:0] PARM_STR  = 4'h4;
  localparam logic [3:0] PARM_NUM4 = 4'h7;
  localparam logic [3:0] PARM_NUM8 = 4'hB;
  localparam logic [3:0] PARM_COPY = 4'h7;

  // Ranges and field values.
  localparam logic [15:0] SCR_MAX       = 16'h01FA;
  localparam logic [15:0] SCR_RESET     = 16'h0000;
  localparam logic [7:0]  STR_LEN_MAX   = 8'h20;
  localparam logic [7:0]  STR_ADDR_MAX  = 8'h7F;
  localparam logic [11:0] TBL_MAX       = 12'h07F;
  localparam logic [3:0]  NEG_DIGIT     = 4'hF;
  localparam logic [3:0]  COPY_TYPE_STR = 4'h0;
  localparam logic [3:0]  COPY_TYPE_NUM = 4'h1;
  localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
  localparam logic [11:0] BCD_HUND      = 12'h064;
  localparam logic [11:0] BCD_TEN       = 12'h00A;
  localparam logic [4:0]  STR_POS_LAST  = 5'h1F;
  localparam int          TBL_ENTRIES   = 128;
  localparam int          STR_CELLS     = 4096;

  // Transmit frame last byte index.
  localparam logic [3:0] TX_SCR_LAST = 4'h5;
  localparam logic [3:0] TX_NUM_LAST = 4'hD;

  // Inter-byte gap limit.
  localparam longint unsigned TIMEOUT_S   = 64'h5;
  localparam longint unsigned CLK_HZ      = 64'h0EE6_B280;
  localparam longint unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;

  function automatic scp_byte_t scp_hex_ascii(input logic [3:0] n);
    return (n <= BCD_DIGIT_MAX) ? ASC_ZERO + {4'h0, n}
                                : ASC_A_OFS + {4'h0, n};
  endfunction

endpackage

// [rtl/scp_hex_digit.sv]
// ASCII hexadecimal digit to four-bit value converter.
`timescale 1ns/1ps
`default_nettype none
module scp_hex_digit (
  input  wire logic            [7:0] ch,
  output logic                 [3:0] nib,
  output logic                       ok
);
  import scp_pkg::*;

  wire is_dec;
  wire is_hex;
  wire [7:0] diff;

  // Only uppercase letters are digits; lowercase is rejected.
  assign is_dec = (ch >= ASC_ZERO) && (ch <= ASC_NINE);
  assign is_hex = (ch >= ASC_A) && (ch <= ASC_F);
  assign diff   = is_dec ? ch - ASC_ZERO : ch - ASC_A_OFS;
  assign nib    = diff[3:0];
  assign ok     = is_dec || is_hex;
endmodule
`default_nettype wire

// [rtl/scp_cmd_parser.sv]
// Screen select and memory table command parser with host notifications.
//
// Overview of operation
// - ESC 30 plus four hex digits selects screen.
// - Zero blanks; one to 1FA pick stored screens.
// - Enquiry answered with current screen number response.
// - Response: ESC, code, three hex digits, CR.
// - Local screen change sends response unprompted.
// - String length field two hex digits, 1..32.
// - String address two hex digits, 00..7F.
// - Marks count as two characters, others one.
// - Excess string characters discarded after stated count.
// - Short string raises timeout error and message.
// - ESC 43, three address, four data digits.
// - Numeral address three hex digits, 000..07F.
// - Four-digit write to wide entry keeps upper.
// - Eight-digit write stores eight digits.
// - Leading F stores seven digits as negative.
// - ESC 2F, type 0 copies string tables.
// - Local numeral change notifies host unprompted.
// - Type 1 copies numerals; BCD addresses 000..127.
// - Byte gap over five seconds raises timeout.
// - Trailing bytes beyond command length ignored.
`timescale 1ns/1ps
`default_nettype none
module scp_cmd_parser #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'(scp_pkg::TIMEOUT_CYC)
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire scp_pkg::scp_byte_t rx_data,
  input  wire logic              rx_valid,
  output scp_pkg::scp_byte_t     tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  input  wire logic              local_screen_valid,
  input  wire logic       [15:0] local_screen_num,
  input  wire logic              local_num_valid,
  input  wire logic        [6:0] local_num_addr,
  input  wire logic       [31:0] local_num_data,
  output logic            [15:0] screen_num,
  output logic                   screen_blank,
  output logic                   timeout_err,
  output logic                   timeout_msg,
  input  wire logic        [6:0] num_rd_addr,
  output logic            [31:0] num_rd_data,
  output logic                   num_rd_wide,
  output logic                   num_rd_neg,
  input  wire logic        [6:0] str_rd_addr,
  input  wire logic        [4:0] str_rd_pos,
  output scp_pkg::scp_byte_t     str_rd_data,
  output logic             [5:0] str_rd_len
);
  import scp_pkg::*;

  scp_st_e           st;
  scp_st_e           next_st;
  scp_cmd_e          cmd;
  scp_cmd_e          next_cmd;
  scp_tx_e           tx_sel;
  logic       [3:0]  parm_need;
  logic       [3:0]  next_need;
  logic       [3:0]  parm_cnt;
  logic       [43:0] acc;
  logic       [31:0] tmo_cnt;
  logic       [6:0]  str_addr;
  logic       [5:0]  str_need;
  logic       [5:0]  str_used;
  logic       [5:0]  str_pos;
  logic       [6:0]  cpy_src;
  logic       [6:0]  cpy_dst;
  logic       [4:0]  cpy_idx;
  logic              scr_pend;
  logic              num_pend;
  logic       [6:0]  ln_addr;
  logic       [31:0] ln_data;
  logic       [3:0]  tx_idx;
  logic       [6:0]  tx_addr;
  logic       [31:0] tx_val;
  logic       [31:0] num_mem [TBL_ENTRIES];
  scp_byte_t         str_mem [STR_CELLS];
  logic       [5:0]  str_len [TBL_ENTRIES];
  logic [TBL_ENTRIES-1:0] num_wide;
  logic [TBL_ENTRIES-1:0] num_neg;

  wire [3:0]   rx_nib;
  wire         rx_ok;
  wire         byte_in;
  wire         busy;
  wire         tmo_hit;
  wire [3:0]   parm_inc;
  wire [43:0]  acc_next;
  wire         last_digit;
  wire [15:0]  f_scr;
  wire [7:0]   f_slen;
  wire [7:0]   f_saddr;
  wire [11:0]  f_a4;
  wire [11:0]  f_a8;
  wire [31:0]  f_d8;
  wire [3:0]   f_ctype;
  wire [11:0]  f_csrc;
  wire [11:0]  f_cdst;
  wire         bcd_ok;
  wire         exe_scr;
  wire         exe_enq;
  wire         exe_str;
  wire         exe_num4;
  wire         exe_num8;
  wire         exe_cpy_str;
  wire         exe_cpy_num;
  wire [5:0]   str_units;
  wire [5:0]   str_sum;
  wire         str_fits;
  wire         str_wr;
  wire         str_done;
  wire         tx_take;
  wire         start_scr;
  wire         start_num;
  wire [63:0]  val_asc;
  wire [111:0] tx_frame;
  wire [111:0] frame_sh;
  wire [7:0]   tx_byte;

  function automatic logic [11:0] bcd3(input logic [11:0] d);
    return 12'(d[11:8]) * BCD_HUND + 12'(d[7:4]) * BCD_TEN + 12'(d[3:0]);
  endfunction

  scp_hex_digit u_hex (
    .ch  (rx_data),
    .nib (rx_nib),
    .ok  (rx_ok)
  );

  // Command field decode from the digit accumulator.
  assign byte_in    = ce && rx_valid;
  assign busy       = (st == ST_CODE) || (st == ST_PARM) || (st == ST_STR);
  assign tmo_hit    = ce && busy && !rx_valid &&
                      (tmo_cnt == TIMEOUT_CYCLES - 32'h1);
  assign parm_inc   = parm_cnt + 4'h1;
  assign acc_next   = {acc[39:0], rx_nib};
  assign last_digit = (st == ST_PARM) && byte_in && rx_ok &&
                      (parm_inc == parm_need);
  assign f_scr      = acc_next[15:0];
  assign f_slen     = acc_next[15:8];
  assign f_saddr    = acc_next[7:0];
  assign f_a4       = acc_next[27:16];
  assign f_a8       = acc_next[43:32];
  assign f_d8       = acc_next[31:0];
  assign f_ctype    = acc_next[27:24];
  assign f_csrc     = bcd3(acc_next[23:12]);
  assign f_cdst     = bcd3(acc_next[11:0]);
  assign bcd_ok     = (acc_next[23:20] <= BCD_DIGIT_MAX) &&
                      (acc_next[19:16] <= BCD_DIGIT_MAX) &&
                      (acc_next[15:12] <= BCD_DIGIT_MAX) &&
                      (acc_next[11:8] <= BCD_DIGIT_MAX) &&
                      (acc_next[7:4] <= BCD_DIGIT_MAX) &&
                      (acc_next[3:0] <= BCD_DIGIT_MAX) &&
                      (f_csrc <= TBL_MAX) && (f_cdst <= TBL_MAX);
  assign exe_scr    = last_digit && (cmd == C_SCR) &&
                      (f_scr <= SCR_MAX);
  assign exe_enq    = (st == ST_CODE) && byte_in &&
                      (rx_data == CODE_ENQ);
  assign exe_str    = last_digit && (cmd == C_STR) &&
                      (f_slen != 8'h00) && (f_slen <= STR_LEN_MAX) &&
                      (f_saddr <= STR_ADDR_MAX);
  assign exe_num4   = last_digit && (cmd == C_NUM4) &&
                      (f_a4 <= TBL_MAX);
  assign exe_num8   = last_digit && (cmd == C_NUM8) &&
                      (f_a8 <= TBL_MAX);
  assign exe_cpy_str = last_digit && (cmd == C_COPY) && bcd_ok &&
                       (f_ctype == COPY_TYPE_STR);
  assign exe_cpy_num = last_digit && (cmd == C_COPY) && bcd_ok &&
                       (f_ctype == COPY_TYPE_NUM);

  // Marks occupy two normal character positions of the length budget.
  assign str_units = (rx_data >= MARK_MIN) ? 6'h02 : 6'h01;
  assign str_sum   = str_used + str_units;
  assign str_fits  = str_sum <= str_need;
  assign str_wr    = (st == ST_STR) && byte_in && str_fits;
  assign str_done  = !str_fits || (str_sum == str_need);

  always_comb begin
    next_st   = st;
    next_cmd  = cmd;
    next_need = parm_need;
    unique case (st)
      ST_IDLE: begin
        // Bytes other than ESC, such as trailing extras, are dropped.
        if (byte_in && (rx_data == ESC)) begin
          next_st = ST_CODE;
        end
      end
      ST_CODE: begin
        if (byte_in) begin
          next_st = ST_PARM;
          if (rx_data == CODE_SCR) begin
            next_cmd  = C_SCR;
            next_need = PARM_SCR;
          end else if (rx_data == CODE_STR) begin
            next_cmd  = C_STR;
            next_need = PARM_STR;
          end else if (rx_data == CODE_NUM4) begin
            next_cmd  = C_NUM4;
            next_need = PARM_NUM4;
          end else if (rx_data == CODE_NUM8) begin
            next_cmd  = C_NUM8;
            next_need = PARM_NUM8;
          end else if (rx_data == CODE_COPY) begin
            next_cmd  = C_COPY;
            next_need = PARM_COPY;
          end else begin
            next_st = ST_IDLE;
          end
        end
      end
      ST_PARM: begin
        if (byte_in && !rx_ok) begin
          next_st = ST_IDLE;
        end else if (last_digit) begin
          next_st = exe_str ? ST_STR : (exe_cpy_str ? ST_COPY : ST_IDLE);
        end
      end
      ST_STR: begin
        if (byte_in && str_done) begin
          next_st = ST_IDLE;
        end
      end
      ST_COPY: begin
        if (cpy_idx == STR_POS_LAST) begin
          next_st = ST_IDLE;
        end
      end
    endcase
    if (tmo_hit) begin
      next_st = ST_IDLE;
    end
  end

  // Parser sequencing.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st          <= ST_IDLE;
      cmd         <= C_NONE;
      parm_need   <= 4'h0;
      parm_cnt    <= 4'h0;
      acc         <= 44'h000_0000_0000;
      tmo_cnt     <= 32'h0000_0000;
      timeout_err <= 1'b0;
      timeout_msg <= 1'b0;
      str_addr    <= 7'h00;
      str_need    <= 6'h00;
      str_used    <= 6'h00;
      str_pos     <= 6'h00;
      cpy_src     <= 7'h00;
      cpy_dst     <= 7'h00;
      cpy_idx     <= 5'h00;
    end else if (ce) begin
      st          <= next_st;
      cmd         <= next_cmd;
      parm_need   <= next_need;
      timeout_err <= tmo_hit;
      tmo_cnt     <= (busy && !byte_in) ? tmo_cnt + 32'h1 : 32'h0000_0000;
      if (tmo_hit) begin
        timeout_msg <= 1'b1;
      end else if (st == ST_IDLE && byte_in && rx_data == ESC) begin
        timeout_msg <= 1'b0;
      end
      if (st == ST_CODE) begin
        parm_cnt <= 4'h0;
      end else if (st == ST_PARM && byte_in) begin
        parm_cnt <= parm_inc;
        acc      <= acc_next;
      end
      if (exe_str) begin
        str_addr <= f_saddr[6:0];
        str_need <= f_slen[5:0];
        str_used <= 6'h00;
        str_pos  <= 6'h00;
      end else if (str_wr) begin
        str_used <= str_sum;
        str_pos  <= str_pos + 6'h01;
      end
      if (exe_cpy_str) begin
        cpy_src <= f_csrc[6:0];
        cpy_dst <= f_cdst[6:0];
        cpy_idx <= 5'h00;
      end else if (st == ST_COPY) begin
        cpy_idx <= cpy_idx + 5'h01;
      end
    end
  end

  // Displayed screen and notification requests; a set beats a clear.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      screen_num <= SCR_RESET;
      scr_pend   <= 1'b0;
      num_pend   <= 1'b0;
      ln_addr    <= 7'h00;
      ln_data    <= 32'h0000_0000;
    end else if (ce) begin
      if (exe_scr) begin
        screen_num <= f_scr;
      end else if (local_screen_valid) begin
        screen_num <= local_screen_num;
      end
      scr_pend <= exe_enq || local_screen_valid ||
                  (scr_pend && !start_scr);
      num_pend <= local_num_valid || (num_pend && !start_num);
      if (local_num_valid) begin
        ln_addr <= local_num_addr;
        ln_data <= local_num_data;
      end
    end
  end

  assign screen_blank = (screen_num == SCR_RESET);

  // Table contents; host commands take priority over local entry.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      num_wide <= '0;
      num_neg  <= '0;
    end else if (ce) begin
      if (exe_num4) begin
        num_mem[f_a4[6:0]][15:0] <= acc_next[15:0];
        if (!num_wide[f_a4[6:0]]) begin
          num_mem[f_a4[6:0]][31:16] <= 16'h0000;
        end
      end else if (exe_num8) begin
        num_mem[f_a8[6:0]]  <= f_d8;
        num_wide[f_a8[6:0]] <= 1'b1;
        num_neg[f_a8[6:0]]  <= (f_d8[31:28] == NEG_DIGIT);
      end else if (exe_cpy_num) begin
        num_mem[f_cdst[6:0]]  <= num_mem[f_csrc[6:0]];
        num_wide[f_cdst[6:0]] <= num_wide[f_csrc[6:0]];
        num_neg[f_cdst[6:0]]  <= num_neg[f_csrc[6:0]];
      end else if (local_num_valid) begin
        num_mem[local_num_addr] <= local_num_data;
      end
      if (str_wr) begin
        str_mem[{str_addr, str_pos[4:0]}] <= rx_data;
      end
      if (st == ST_STR && byte_in && str_done) begin
        str_len[str_addr] <= str_fits ? str_pos + 6'h01 : str_pos;
      end else if (st == ST_STR && tmo_hit) begin
        str_len[str_addr] <= str_pos;
      end
      if (st == ST_COPY) begin
        str_mem[{cpy_dst, cpy_idx}] <= str_mem[{cpy_src, cpy_idx}];
        if (cpy_idx == STR_POS_LAST) begin
          str_len[cpy_dst] <= str_len[cpy_src];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      num_rd_data <= 32'h0000_0000;
      num_rd_wide <= 1'b0;
      num_rd_neg  <= 1'b0;
      str_rd_data <= 8'h00;
      str_rd_len  <= 6'h00;
    end else if (ce) begin
      num_rd_data <= num_mem[num_rd_addr];
      num_rd_wide <= num_wide[num_rd_addr];
      num_rd_neg  <= num_neg[num_rd_addr];
      str_rd_data <= str_mem[{str_rd_addr, str_rd_pos}];
      str_rd_len  <= str_len[str_rd_addr];
    end
  end

  // Outgoing frames, one byte index per step.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_asc
      assign val_asc[8*g +: 8] = scp_hex_ascii(tx_val[4*g +: 4]);
    end
  endgenerate

  assign tx_frame = (tx_sel == TX_SCR) ?
    {ESC, CODE_SCR_RSP, scp_hex_ascii(tx_val[11:8]),
     scp_hex_ascii(tx_val[7:4]), scp_hex_ascii(tx_val[3:0]), CR,
     64'h0000_0000_0000_0000} :
    {ESC, CODE_NUM_NTF, scp_hex_ascii(4'h0),
     scp_hex_ascii({1'b0, tx_addr[6:4]}), scp_hex_ascii(tx_addr[3:0]),
     val_asc, CR};
  assign frame_sh  = tx_frame << {tx_idx, 3'b000};
  assign tx_byte   = frame_sh[111:104];
  assign tx_take   = !tx_valid || tx_ready;
  assign start_scr = (tx_sel == TX_NONE) && tx_take && scr_pend;
  assign start_num = (tx_sel == TX_NONE) && tx_take && !scr_pend && num_pend;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_sel   <= TX_NONE;
      tx_idx   <= 4'h0;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      tx_addr  <= 7'h00;
      tx_val   <= 32'h0000_0000;
    end else if (ce && tx_take) begin
      if (tx_sel != TX_NONE) begin
        tx_data  <= tx_byte;
        tx_valid <= 1'b1;
        tx_idx   <= tx_idx + 4'h1;
        if (tx_idx == ((tx_sel == TX_SCR) ? TX_SCR_LAST : TX_NUM_LAST)) begin
          tx_sel <= TX_NONE;
        end
      end else if (start_scr || start_num) begin
        tx_data  <= ESC;
        tx_valid <= 1'b1;
        tx_idx   <= 4'h1;
        tx_sel   <= start_scr ? TX_SCR : TX_NUM;
        tx_addr  <= ln_addr;
        tx_val   <= start_scr ? {16'h0000, screen_num} : ln_data;
      end else begin
        tx_valid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_scr_start;
    $rose(tx_sel == TX_SCR);
  endsequence
  sequence s_scr_end;
    $fell(tx_sel == TX_SCR);
  endsequence

  property p_scr_sel;
    exe_scr |=> (screen_num == $past(f_scr));
  endproperty
  a_scr_sel: assert property (p_scr_sel)
    else $error("screen select not applied");

  property p_scr_range;
    screen_num <= SCR_MAX || $past(local_screen_valid);
  endproperty
  a_scr_range: assert property (p_scr_range)
    else $error("host screen number out of range");

  property p_enq;
    exe_enq |=> scr_pend;
  endproperty
  a_enq: assert property (p_enq)
    else $error("enquiry did not request a response");

  property p_rsp_frame;
    s_scr_start |-> tx_valid && tx_data == ESC;
  endproperty
  a_rsp_frame: assert property (p_rsp_frame)
    else $error("response does not open with escape");

  property p_rsp_end;
    s_scr_end |-> tx_valid && tx_data == CR;
  endproperty
  a_rsp_end: assert property (p_rsp_end)
    else $error("response does not close with carriage return");

  property p_local;
    ce && local_screen_valid && !exe_scr |=>
      scr_pend && screen_num == $past(local_screen_num);
  endproperty
  a_local: assert property (p_local)
    else $error("local screen change not reported");

  property p_str_bound;
    st == ST_STR |-> str_used <= str_need && str_need <= 6'h20 &&
                     str_need != 6'h00;
  endproperty
  a_str_bound: assert property (p_str_bound)
    else $error("string count beyond stated length");

  property p_tmo;
    tmo_hit |=> timeout_err && timeout_msg && st == ST_IDLE;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout not flagged");

  property p_num4_keep;
    exe_num4 && num_wide[f_a4[6:0]] |=>
      num_mem[$past(f_a4[6:0])][31:16] ==
        $past(num_mem[f_a4[6:0]][31:16]);
  endproperty
  a_num4_keep: assert property (p_num4_keep)
    else $error("upper digits lost on four digit write");

  property p_neg;
    exe_num8 && f_d8[31:28] == NEG_DIGIT |=> num_neg[$past(f_a8[6:0])];
  endproperty
  a_neg: assert property (p_neg)
    else $error("negative value not marked");

  property p_ntf;
    ce && local_num_valid |=> num_pend;
  endproperty
  a_ntf: assert property (p_ntf)
    else $error("local numeral change not reported");

  property p_trail;
    ce && st == ST_IDLE && rx_valid && rx_data != ESC |=> st == ST_IDLE;
  endproperty
  a_trail: assert property (p_trail)
    else $error("stray byte started a command");

endmodule
`default_nettype wire

// [test/scp_host_model.sv]
// Host controller model: sends command bytes and takes the reply stream.
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  logic [1:0] cnt = 2'h0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // Bytes follow each other closely, far inside the gap limit.
  task automatic send_byte(input logic [7:0] b);
    @(negedge core_clk);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(negedge core_clk);
    rx_data <= ~b;
    rx_valid <= 1'b0;
  endtask
  // In slow mode the reply side is ready one cycle in four.
  always @(negedge core_clk) begin
    cnt <= cnt + 2'h1;
    tx_ready <= !slow || (cnt == 2'h3);
  end
  always @(posedge core_clk)
    if (tx_valid && tx_ready) got.push_back(tx_data);
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the screen and table command parser.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scp_pkg::*;
  localparam logic [31:0] TMO = 32'd50;
  typedef struct { string d; logic [15:0] s; } scp_row_s;
  logic        core_clk, rst_n = 1'b0, ce = 1'b1, lsv = 1'b0, lnv = 1'b0;
  logic        tv, tr, rv, blank, terr, tmsg, nw, nn;
  logic [7:0]  rd, td, srd;
  logic [15:0] lsn = 16'h0000, scr;
  logic [6:0]  lna = 7'h00, nra = 7'h00, sra = 7'h00;
  logic [31:0] lnd = 32'h0000_0000, nrd;
  logic [4:0]  srp = 5'h00;
  logic [5:0]  srl;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          n;
  scp_row_s    rows[6] = '{'{"0000", 16'h0000}, '{"01FA", 16'h01FA},
    '{"01FB", 16'h01FA}, '{"0123", 16'h0123}, '{"01G0", 16'h0123},
    '{"0001", 16'h0001}};

  scp_cmd_parser #(.TIMEOUT_CYCLES(TMO)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .rx_data(rd),
    .rx_valid(rv), .tx_data(td), .tx_valid(tv), .tx_ready(tr),
    .local_screen_valid(lsv), .local_screen_num(lsn),
    .local_num_valid(lnv), .local_num_addr(lna), .local_num_data(lnd),
    .screen_num(scr), .screen_blank(blank), .timeout_err(terr),
    .timeout_msg(tmsg), .num_rd_addr(nra), .num_rd_data(nrd),
    .num_rd_wide(nw), .num_rd_neg(nn), .str_rd_addr(sra),
    .str_rd_pos(srp), .str_rd_data(srd), .str_rd_len(srl));
  scp_host_model host (.core_clk(core_clk), .rx_data(rd), .rx_valid(rv),
    .tx_data(td), .tx_valid(tv), .tx_ready(tr));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) host.send_byte(s[i]);
  endtask
  task automatic frame(input string s);
    n = 0;
    while (host.got.size() < s.len() && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(host.got.size()), 32'(s.len()));
    for (int i = 0; i < s.len(); i++)
      if (host.got.size() > 0) chk({24'h0, host.got.pop_front()}, 32'(s[i]));
  endtask
  task automatic rd_num(input logic [6:0] a, input logic [31:0] d,
                        input logic w, input logic ng);
    @(negedge core_clk);
    nra = a;
    @(negedge core_clk);
    chk(nrd, d);
    chk({30'h0, nw, nn}, {30'h0, w, ng});
  endtask
  task automatic rd_str(input logic [6:0] a, input logic [4:0] p,
                        input logic [7:0] d, input logic [5:0] l);
    @(negedge core_clk);
    sra = a;
    srp = p;
    @(negedge core_clk);
    chk({18'h0, srl, srd}, {18'h0, l, d});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge core_clk);
    chk({scr, 12'h0, blank, terr, tmsg, tv}, 32'h0000_0008);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      send({"\0330", rows[i].d});
      repeat (2) @(negedge core_clk);
      chk({scr, 15'h0, blank}, {rows[i].s, 15'h0, ~|rows[i].s});
    end
    host.slow = 1'b1;
    send("\0331");
    frame("\033Y001\r");
    host.slow = 1'b0;
    lsn = 16'h0123;
    lsv = 1'b1;
    @(negedge core_clk);
    lsv = 1'b0;
    frame("\033Y123\r");
    chk({16'h0000, scr}, 32'h0000_0123);
    // A full screen select sent while the clock enable is low must not land.
    ce = 1'b0;
    send("\03300005");
    ce = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({16'h0000, scr}, 32'h0000_0123);
    send("\033D00512345678");
    rd_num(7'h05, 32'h1234_5678, 1'b1, 1'b0);
    send("\033C005ABCD");
    rd_num(7'h05, 32'h1234_ABCD, 1'b1, 1'b0);
    send("\033C07F0009");
    rd_num(7'h7F, 32'h0000_0009, 1'b0, 1'b0);
    send("\033C0001111");
    send("\033C0802222");
    rd_num(7'h00, 32'h0000_1111, 1'b0, 1'b0);
    send("\033D006F1234567");
    rd_num(7'h06, 32'hF123_4567, 1'b1, 1'b1);
    send("\033/1005010");
    repeat (40) @(negedge core_clk);
    rd_num(7'h0A, 32'h1234_ABCD, 1'b1, 1'b0);
    send("\033A0307A\200B");
    rd_str(7'h07, 5'h00, 8'h41, 6'h02);
    rd_str(7'h07, 5'h01, 8'h80, 6'h02);
    send("\033/0007009");
    repeat (40) @(negedge core_clk);
    rd_str(7'h09, 5'h01, 8'h80, 6'h02);
    send("\033A0201X");
    n = 0;
    while (terr !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(n > 45 && n < 60), 32'h0000_0001);
    @(negedge core_clk);
    chk({30'h0, terr, tmsg}, 32'h0000_0001);
    rd_str(7'h01, 5'h00, 8'h58, 6'h01);
    send("\03300001");
    chk({31'h0, tmsg}, 32'h0000_0000);
    chk({16'h0000, scr}, 32'h0000_0001);
    lna = 7'h03;
    lnd = 32'h0000_0042;
    lnv = 1'b1;
    @(negedge core_clk);
    lnv = 1'b0;
    frame("\033F00300000042\r");
    rd_num(7'h03, 32'h0000_0042, 1'b0, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    chk({scr, 12'h0, blank, terr, tmsg, tv}, 32'h0000_0008);
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
